// >>> port_rmw_pkg.sv
// Constants, commands and states for the read-modify-write port block.
package port_rmw_pkg;
  localparam int PORT_W = 8;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] BIT_ONE = 8'h01;
  localparam logic [7:0] SYNC_RST = 8'h00;
  localparam int INSTR_CYCLES = 4;

  typedef enum logic [2:0] {
    bit_set_op = 3'h0,
    bit_clear_op = 3'h1,
    port_write_op = 3'h2,
    port_read_op = 3'h3,
    direction_load_op = 3'h4
  } op_e;

  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_q1 = 5'h02,
    st_q2 = 5'h04,
    st_q3 = 5'h08,
    st_q4 = 5'h10
  } state_e;

  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = BIT_ONE << sel;
  endfunction
endpackage

// >>> port_sample_if.sv
// Carries the synchronised pin levels from the sampler to the port logic.
`timescale 1ns/1ps
`default_nettype none
interface port_sample_if;
  logic [7:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface
`default_nettype wire

// >>> port_pin_sync.sv
// Two-flop synchroniser for the eight port pin inputs.
`timescale 1ns/1ps
`default_nettype none
module port_pin_sync
  import port_rmw_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] pin_in_i,
  port_sample_if.src smp
);
  logic [7:0] meta_r;
  logic [7:0] lvl_r;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= SYNC_RST;
      lvl_r <= SYNC_RST;
    end else begin
      meta_r <= pin_in_i;
      lvl_r <= meta_r;
    end
  end

  assign smp.lvl = lvl_r;
endmodule
`default_nettype wire

// >>> bidir_port_rmw_access.sv
// Eight-bit bidirectional port with read-modify-write bit operations.
// Operation
// - Bit set/clear reads all eight bits, changes one, writes all back.
// - The read phase samples pin levels, so input pins overwrite their latches.
// - An input pin is not driven; switched to output it drives its latch.
// - Writes update latches at cycle end; reads take data at cycle start.
`timescale 1ns/1ps
`default_nettype none
module bidir_port_rmw_access
  import port_rmw_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic op_valid_i,
  input wire logic [2:0] op_code_i,
  input wire logic [2:0] op_bit_i,
  input wire logic [7:0] op_wdata_i,
  output logic busy_o,
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  input wire logic [7:0] pin_in_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_n_o
);
  // Pins reach the port logic only through two flops, so a read right after a write sees the old level.
  port_sample_if smp ();

  port_pin_sync u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .pin_in_i(pin_in_i),
    .smp(smp)
  );

  state_e st_r;
  state_e st_nxt;
  op_e op_r;
  op_e op_nxt;
  logic [2:0] bit_r;
  logic [2:0] bit_nxt;
  logic [7:0] w_r;
  logic [7:0] w_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic [7:0] dir_r;
  logic [7:0] dir_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rdv_r;
  logic rdv_nxt;
  logic busy_r;
  logic busy_nxt;

  // An instruction runs four phases; pins are taken in the first, latches change in the last.
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    bit_nxt = bit_r;
    w_nxt = w_r;
    rd_nxt = rd_r;
    data_nxt = data_r;
    dir_nxt = dir_r;
    rdata_nxt = rdata_r;
    rdv_nxt = 1'b0;
    unique case (st_r)
      st_idle: begin
        if (op_valid_i) begin
          op_nxt = op_e'(op_code_i);
          bit_nxt = op_bit_i;
          w_nxt = op_wdata_i;
          st_nxt = st_q1;
        end
      end
      st_q1: begin
        rd_nxt = smp.lvl;
        st_nxt = st_q2;
      end
      st_q2: st_nxt = st_q3;
      st_q3: st_nxt = st_q4;
      st_q4: begin
        unique case (op_r)
          bit_set_op: data_nxt = rd_r | bit_mask(bit_r);
          bit_clear_op: data_nxt = rd_r & ~bit_mask(bit_r);
          port_write_op: data_nxt = w_r;
          port_read_op: begin
            rdata_nxt = rd_r;
            rdv_nxt = 1'b1;
          end
          direction_load_op: dir_nxt = w_r;
          default: data_nxt = data_r;
        endcase
        st_nxt = st_idle;
      end
      default: st_nxt = st_idle;
    endcase
    busy_nxt = (st_nxt != st_idle);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= st_idle;
      op_r <= bit_set_op;
      bit_r <= 3'h0;
      w_r <= DATA_RST;
      rd_r <= DATA_RST;
      data_r <= DATA_RST;
      dir_r <= DIR_RST;
      rdata_r <= DATA_RST;
      rdv_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      bit_r <= bit_nxt;
      w_r <= w_nxt;
      rd_r <= rd_nxt;
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      rdata_r <= rdata_nxt;
      rdv_r <= rdv_nxt;
      busy_r <= busy_nxt;
    end
  end

  // The latch always sits on the pin driver; the direction bit alone gates it.
  assign pin_out_o = data_r;
  assign pin_oe_n_o = dir_r;
  assign rdata_o = rdata_r;
  assign rdata_valid_o = rdv_r;
  assign busy_o = busy_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // An instruction starts when its request is taken and ends in its write-back phase.
  sequence s_start;
    st_r == st_idle && op_valid_i;
  endsequence

  sequence s_end;
    st_r == st_q4;
  endsequence

  sequence s_write_end;
    st_r == st_q4 && op_r == port_write_op;
  endsequence

  sequence s_dir_end;
    st_r == st_q4 && op_r == direction_load_op;
  endsequence

  // Codes outside the five commands still take a full instruction but touch nothing.
  sequence s_odd_end;
    st_r == st_q4 && !(op_r inside {bit_set_op, bit_clear_op, port_write_op, port_read_op,
      direction_load_op});
  endsequence

  a_phase_count: assert property (s_start |-> ##4 s_end)
    else $error("Instruction did not reach its write phase in four cycles.");

  a_pins_sampled: assert property (st_r == st_q1 |=> rd_r == $past(smp.lvl))
    else $error("Read phase did not capture the pin levels.");

  a_set_whole_port: assert property ((s_end and op_r == bit_set_op)
      |=> pin_out_o == ($past(rd_r) | bit_mask($past(bit_r))))
    else $error("Bit set did not write back the read port value with one bit set.");

  a_clear_keeps_high: assert property ((s_end and op_r == bit_clear_op)
      |=> pin_out_o == ($past(rd_r) & ~bit_mask($past(bit_r))))
    else $error("Bit clear did not write back the other sampled bits.");

  a_latch_end_only: assert property (st_r != st_q4 |=> $stable(pin_out_o) && $stable(pin_oe_n_o))
    else $error("Port latches changed outside the end of an instruction.");

  a_dir_load: assert property ((s_end and op_r == direction_load_op)
      |=> pin_oe_n_o == $past(w_r) && $stable(pin_out_o))
    else $error("Direction load did not copy the value or disturbed the data latch.");

  a_read_result: assert property ((s_end and op_r == port_read_op)
      |=> rdata_valid_o && rdata_o == $past(rd_r) ##1 !rdata_valid_o)
    else $error("Port read did not return the sampled value for one cycle.");

  a_busy_span: assert property (s_start |=> busy_o [*4] ##1 !busy_o)
    else $error("Busy did not span exactly the instruction.");

  // A request raised while an instruction runs must not disturb the captured operands.
  a_busy_refuses: assert property (busy_o
      |=> $stable(op_r) && $stable(bit_r) && $stable(w_r))
    else $error("Operands changed while an instruction was running.");

  a_write_latch: assert property (s_write_end
      |=> pin_out_o == $past(w_r) && $stable(pin_oe_n_o))
    else $error("Port write did not load the data latches alone.");

  a_rdata_holds: assert property (!(st_r == st_q4 && op_r == port_read_op)
      |=> $stable(rdata_o))
    else $error("Read data changed without a port read.");

  a_valid_only_read: assert property (rdata_valid_o
      |-> $past(st_r) == st_q4 && $past(op_r) == port_read_op)
    else $error("Read valid pulsed without a finished port read.");

  a_dir_drives_latch: assert property (s_dir_end
      |=> (~pin_oe_n_o & pin_out_o) == (~$past(w_r) & $past(data_r)))
    else $error("A pin switched to output did not drive its held latch value.");

  a_rmw_dir_kept: assert property ((st_r == st_q4
      && (op_r == bit_set_op || op_r == bit_clear_op)) |=> $stable(pin_oe_n_o))
    else $error("Bit set or clear disturbed the direction latches.");

  a_odd_code_idle: assert property (s_odd_end
      |=> $stable(pin_out_o) && $stable(pin_oe_n_o) && !rdata_valid_o)
    else $error("An undefined code changed the port.");
endmodule
`default_nettype wire

// >>> pin_load.sv
// External pull-ups and drivers seen by the port pins.
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_n_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pin_lvl_o
);
  // Drives only released pins; undriven ones rise to the pull-up.
  assign pin_lvl_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext_en_i & ext_val_i)
    | (pin_oe_n_i & ~ext_en_i);
endmodule
`default_nettype wire

// >>> bidir_port_rmw_access_tb.sv
// Testbench for the read-modify-write port block.
`timescale 1ns/1ps
`default_nettype none
module bidir_port_rmw_access_tb;
  import port_rmw_pkg::*;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic op_valid_i = 1'b0;
  logic [2:0] op_code_i = 3'h0;
  logic [2:0] op_bit_i = 3'h0;
  logic [7:0] op_wdata_i = 8'h00;
  logic busy_o;
  logic rdata_valid_o;
  logic [7:0] rdata_o;
  logic [7:0] pin_in_i;
  logic [7:0] pin_out_o;
  logic [7:0] pin_oe_n_o;
  int fails = 0;
  int tests_run = 0;
  always #5 core_clk_i = ~core_clk_i;
  bidir_port_rmw_access dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_bit_i(op_bit_i),
    .op_wdata_i(op_wdata_i), .busy_o(busy_o), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_n_o(pin_oe_n_o));
  pin_load load_u (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o), .ext_en_i(8'h30),
    .ext_val_i(8'h20), .pin_lvl_o(pin_in_i));
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Runs one instruction after a settling gap; data latches must hold while busy.
  task automatic run(input logic [2:0] code, input logic [2:0] b, input logic [7:0] wd);
    int n;
    logic [7:0] old;
    n = 0;
    repeat (3) @(posedge core_clk_i);
    #1;
    old = pin_out_o;
    op_valid_i = 1'b1;
    op_code_i = code;
    op_bit_i = b;
    op_wdata_i = wd;
    @(posedge core_clk_i);
    #1;
    op_valid_i = 1'b0;
    while (busy_o === 1'b1 && n < 8) begin
      chk(pin_out_o, old);
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n != INSTR_CYCLES) begin
      fails++;
      $display("CHECK FAILED at %0t: busy lasted %0d cycles", $time, n);
      give_verdict();
    end
    chk({7'h00, rdata_valid_o}, {7'h00, code == port_read_op});
  endtask
  task automatic scn_stale_latch();
    run(direction_load_op, 3'h0, 8'hf0);
    chk(pin_oe_n_o, 8'hf0);
    run(port_write_op, 3'h0, 8'h05);
    chk(pin_out_o, 8'h05);
    run(bit_clear_op, 3'h7, 8'h00);
    chk(pin_out_o, 8'h65);
    run(bit_clear_op, 3'h6, 8'h00);
    chk(pin_out_o, 8'ha5);
    run(direction_load_op, 3'h0, 8'h3f);
    chk(pin_out_o, 8'ha5);
    chk(pin_in_i, 8'haf);
  endtask
  task automatic scn_set_read();
    run(bit_set_op, 3'h4, 8'h00);
    chk(pin_out_o, 8'hbf);
    run(port_read_op, 3'h0, 8'h00);
    chk(rdata_o, 8'haf);
  endtask
  task automatic scn_odd_code();
    run(3'h5, 3'h2, 8'h00);
    chk(pin_out_o, 8'hbf);
    chk(pin_oe_n_o, 8'h3f);
    chk(rdata_o, 8'haf);
  endtask
  task automatic scn_reset();
    @(posedge core_clk_i);
    #1;
    nrst_i = 1'b0;
    #1;
    chk(pin_out_o, DATA_RST);
    chk(pin_oe_n_o, DIR_RST);
    chk({6'h00, busy_o, rdata_valid_o}, 8'h00);
    chk(rdata_o, DATA_RST);
    repeat (16) @(posedge core_clk_i);
    #1;
    nrst_i = 1'b1;
    run(port_read_op, 3'h0, 8'h00);
    chk(rdata_o, 8'hef);
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    #1;
    nrst_i = 1'b1;
    scn_stale_latch();
    scn_set_read();
    scn_odd_code();
    scn_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
